//--- core/vcr_regs.vh
/*
  vc0 resource register block: offsets, field positions, reset values
  and load-sequencer counts, shared by the design files.
  assumes byte addressing on a 12-bit configuration offset.
*/
`ifndef VCR_REGS_VH
`define VCR_REGS_VH

`define VCR_ADDR_W        12
`define VCR_CAP_OFFS      12'h150
`define VCR_CTRL_OFFS     12'h154
`define VCR_STAT_OFFS     12'h158
`define VCR_VC_CAP_BASE   12'h140

`define VCR_PARB_CAP_LSB  0
`define VCR_PARB_CAP_RST  8'h19
`define VCR_SW_OPT_BIT    14
`define VCR_SW_OPT_RST    1'b0
`define VCR_SNOOP_BIT     15
`define VCR_SNOOP_RST     1'b0
`define VCR_MAX_TS_LSB    16
`define VCR_MAX_TS_RST    7'h7F
`define VCR_TBL_OFFS_LSB  24
`define VCR_TBL_OFFS_RST  8'h04
`define VCR_TBL_UNIT_SH   4

`define VCR_TC_MAP_LSB    0
`define VCR_TC_MAP_RST    8'hFF
`define VCR_LOAD_BIT      16
`define VCR_SEL_LSB       17
`define VCR_SEL_RST       3'h0
`define VCR_SEL_RR        3'h0
`define VCR_SEL_WRR128    3'h3
`define VCR_VCID_LSB      24
`define VCR_VCID_RST      3'h0
`define VCR_EN_BIT        31
`define VCR_EN_RST        1'b1

`define VCR_TBL_STAT_BIT  16
`define VCR_NEG_BIT       17

`define VCR_TBL_AW        4
`define VCR_TBL_LAST      4'hF

`endif

//--- core/vcr_resource_regs.v
/*
  vc0 resource capability, control and status registers with the port
  arbitration table store and its load sequencer.
  assumes a one-cycle strobe register port on core_clk_i, and that the
  negotiation-pending level comes from logic on the same clock.
*/
// Contract
// - capability bits 7:0 read 19h: round robin, wrr and time-based wrr with 128 phases.
// - time-based wrr is never accepted as the scheme of channel 0.
// - capability bit 14, switching-optimized-only, always reads 0.
// - capability bit 15, snoop rejection, always reads 0.
// - capability bits 22:16 hold max time slots minus one, 7Fh, reloadable from eeprom.
// - capability bits 31:24 give the table offset in sixteen-byte units, 04h.
// - control bits 7:0 are the writable tc map, reset FFh, reloadable from eeprom.
// - writing 1 to control bit 16 applies the table; the bit always reads 0.
// - control bits 19:17 select the scheme; only 000b and 011b stick, others give 000b.
// - control bits 26:24 hold the read-only vc id 000b.
// - control bit 31 is the vc enable, reset 1.
// - status bit 16 sets whenever software writes a table entry.
// - status bit 16 clears when the load of the stored table finishes.
// - status bit 17 reads 1 while vc negotiation is pending.
// - the three registers decode at 150h, 154h and 158h.
`timescale 1ns/1ps
`include "vcr_regs.vh"
module vcr_resource_regs (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        ce_i,
  input  wire [11:0] addr_i,
  input  wire [31:0] wr_data_i,
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  output reg  [31:0] rd_data_o,
  input  wire        eeprom_load_i,
  input  wire [7:0]  eeprom_tc_map_i,
  input  wire [6:0]  eeprom_max_ts_i,
  input  wire        neg_pending_i,
  output reg  [7:0]  tc_map_o,
  output reg  [2:0]  arb_select_o,
  output reg         vc_enable_o,
  output reg         tbl_load_busy_o,
  output reg         tbl_load_valid_o,
  output reg  [3:0]  tbl_load_index_o,
  output reg  [31:0] tbl_load_data_o
);

  localparam ST_IDLE = 2'b00;
  localparam ST_READ = 2'b01;
  localparam ST_WAIT = 2'b10;

  localparam [11:0] TBL_BASE =
    `VCR_VC_CAP_BASE + {`VCR_TBL_OFFS_RST, {`VCR_TBL_UNIT_SH{1'b0}}};

  function tbl_hit;
    input [11:0] a;
    begin
      tbl_hit = (a[11:2] >= TBL_BASE[11:2]) &&
                (a[11:2] <= TBL_BASE[11:2] + {6'h00, `VCR_TBL_LAST});
    end
  endfunction

  function [2:0] sel_filter;
    input [2:0] s;
    begin
      if (s == `VCR_SEL_RR || s == `VCR_SEL_WRR128) begin
        sel_filter = s;
      end else begin
        sel_filter = `VCR_SEL_RR;
      end
    end
  endfunction

  reg  [6:0]  max_ts_reg;
  reg         tbl_stat_reg;
  reg         neg_reg;
  reg  [1:0]  seq_state_reg;
  reg  [3:0]  seq_idx_reg;
  reg         rd_pend_reg;
  reg  [3:0]  pend_idx_reg;
  reg  [31:0] rd_data_next;
  wire [31:0] mem_q;
  wire        hit_cap  = (addr_i == `VCR_CAP_OFFS);
  wire        hit_ctrl = (addr_i == `VCR_CTRL_OFFS);
  wire        hit_stat = (addr_i == `VCR_STAT_OFFS);
  wire        tbl_wr   = wr_en_i && tbl_hit(addr_i);
  wire [3:0]  tbl_widx = addr_i[5:2] - TBL_BASE[5:2];
  wire        load_req = wr_en_i && hit_ctrl && wr_data_i[`VCR_LOAD_BIT];
  wire        seq_rd   = (seq_state_reg == ST_READ);
  wire        load_done = rd_pend_reg && (pend_idx_reg == `VCR_TBL_LAST);

  vcr_tbl_mem #(
    .AW (`VCR_TBL_AW),
    .DW (32)
  ) u_tbl (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .wr_en_i    (tbl_wr),
    .wr_addr_i  (tbl_widx),
    .wr_data_i  (wr_data_i),
    .rd_en_i    (seq_rd),
    .rd_addr_i  (seq_idx_reg),
    .rd_data_o  (mem_q)
  );

  // read mux
  always @* begin
    rd_data_next = 32'h0000_0000;
    if (hit_cap) begin
      rd_data_next[`VCR_PARB_CAP_LSB +: 8] = `VCR_PARB_CAP_RST;
      rd_data_next[`VCR_SW_OPT_BIT]        = `VCR_SW_OPT_RST;
      rd_data_next[`VCR_SNOOP_BIT]         = `VCR_SNOOP_RST;
      rd_data_next[`VCR_MAX_TS_LSB +: 7]   = max_ts_reg;
      rd_data_next[`VCR_TBL_OFFS_LSB +: 8] = `VCR_TBL_OFFS_RST;
    end else if (hit_ctrl) begin
      rd_data_next[`VCR_TC_MAP_LSB +: 8] = tc_map_o;
      rd_data_next[`VCR_LOAD_BIT]        = 1'b0;
      rd_data_next[`VCR_SEL_LSB +: 3]    = arb_select_o;
      rd_data_next[`VCR_VCID_LSB +: 3]   = `VCR_VCID_RST;
      rd_data_next[`VCR_EN_BIT]          = vc_enable_o;
    end else if (hit_stat) begin
      rd_data_next[`VCR_TBL_STAT_BIT] = tbl_stat_reg;
      rd_data_next[`VCR_NEG_BIT]      = neg_reg;
    end
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o    <= 32'h0000_0000;
      max_ts_reg   <= `VCR_MAX_TS_RST;
      tc_map_o     <= `VCR_TC_MAP_RST;
      arb_select_o <= `VCR_SEL_RST;
      vc_enable_o  <= `VCR_EN_RST;
      tbl_stat_reg <= 1'b0;
      neg_reg      <= 1'b0;
    end else if (ce_i) begin
      if (rd_en_i) begin
        rd_data_o <= rd_data_next;
      end
      if (eeprom_load_i) begin
        max_ts_reg <= eeprom_max_ts_i;
      end
      if (wr_en_i && hit_ctrl) begin
        tc_map_o     <= wr_data_i[`VCR_TC_MAP_LSB +: 8];
        arb_select_o <= sel_filter(wr_data_i[`VCR_SEL_LSB +: 3]);
        vc_enable_o  <= wr_data_i[`VCR_EN_BIT];
      end else if (eeprom_load_i) begin
        tc_map_o <= eeprom_tc_map_i;
      end
      if (tbl_wr) begin
        tbl_stat_reg <= 1'b1;
      end else if (load_done) begin
        tbl_stat_reg <= 1'b0;
      end
      neg_reg <= neg_pending_i;
    end
  end

  // table load sequencer: walks every stored word out to the arbiter
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_state_reg    <= ST_IDLE;
      seq_idx_reg      <= 4'h0;
      rd_pend_reg      <= 1'b0;
      pend_idx_reg     <= 4'h0;
      tbl_load_busy_o  <= 1'b0;
      tbl_load_valid_o <= 1'b0;
      tbl_load_index_o <= 4'h0;
      tbl_load_data_o  <= 32'h0000_0000;
    end else if (ce_i) begin
      rd_pend_reg      <= seq_rd;
      pend_idx_reg     <= seq_idx_reg;
      tbl_load_valid_o <= rd_pend_reg;
      if (rd_pend_reg) begin
        tbl_load_index_o <= pend_idx_reg;
        tbl_load_data_o  <= mem_q;
      end
      case (seq_state_reg)
        ST_IDLE: begin
          if (load_req) begin
            seq_state_reg   <= ST_READ;
            seq_idx_reg     <= 4'h0;
            tbl_load_busy_o <= 1'b1;
          end
        end
        ST_READ: begin
          seq_idx_reg <= seq_idx_reg + 4'h1;
          if (seq_idx_reg == `VCR_TBL_LAST) begin
            seq_state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (load_done) begin
            seq_state_reg   <= ST_IDLE;
            tbl_load_busy_o <= 1'b0;
          end
        end
        default: begin
          seq_state_reg   <= ST_IDLE;
          tbl_load_busy_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // vcr_resource_regs

//--- core/vcr_tbl_mem.v
/*
  port arbitration table store: one write port, one read port,
  registered read data.
  assumes write and read requests come from logic on the same clock.
*/
`timescale 1ns/1ps
module vcr_tbl_mem #(
  parameter AW = 4,
  parameter DW = 32
) (
  input  wire          core_clk_i,
  input  wire          reset_i,
  input  wire          ce_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire          rd_en_i,
  input  wire [AW-1:0] rd_addr_i,
  output reg  [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  always @(posedge core_clk_i) begin
    if (ce_i && wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= {DW{1'b0}};
    end else if (ce_i && rd_en_i) begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule // vcr_tbl_mem

//--- testbench/vcr_resource_regs_monitor.sv
/* assertions on the vc0 resource register ports.
   assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
module vcr_monitor (
  input logic        core_clk_i,
  input logic        reset_i,
  input logic        ce_i,
  input logic [11:0] addr_i,
  input logic [31:0] wr_data_i,
  input logic        wr_en_i,
  input logic        rd_en_i,
  input logic [31:0] rd_data_o,
  input logic [7:0]  tc_map_o,
  input logic [2:0]  arb_select_o,
  input logic        vc_enable_o,
  input logic        tbl_load_busy_o,
  input logic        tbl_load_valid_o,
  input logic [3:0]  tbl_load_index_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [31:0] wd_q;
  wire         rd_c   = ce_i && rd_en_i;
  wire         wr_ctl = ce_i && wr_en_i && addr_i == 12'h154;
  always_ff @(posedge core_clk_i) wd_q <= wr_data_i;
  a_cap_fields: assert property (
    rd_c && addr_i == 12'h150 |=> (rd_data_o & 32'hFF80FFFF) == 32'h04000019)
    else $error("capability fields wrong");
  a_ctrl_rsvd: assert property (
    rd_c && addr_i == 12'h154 |=> (rd_data_o & 32'h7FF1FF00) == 32'h00000000)
    else $error("control fixed bits wrong");
  a_stat_rsvd: assert property (
    rd_c && addr_i == 12'h158 |=> (rd_data_o & 32'hFFFCFFFF) == 32'h00000000)
    else $error("status reserved bits wrong");
  a_unmapped_zero: assert property (
    rd_c && !(addr_i inside {12'h150, 12'h154, 12'h158}) |=> rd_data_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_ctrl_write: assert property (
    wr_ctl |=> tc_map_o == wd_q[7:0] && vc_enable_o == wd_q[31]
      && arb_select_o == (wd_q[19:17] == 3'h3 ? 3'h3 : 3'h0))
    else $error("control write wrong");
  a_rd_hold: assert property (!rd_c |=> $stable(rd_data_o))
    else $error("read data moved");
  a_load_start: assert property (
    wr_ctl && wr_data_i[16] && !tbl_load_busy_o |=> tbl_load_busy_o)
    else $error("load did not start");
  a_load_span: assert property ($rose(tbl_load_busy_o) |->
    ##2 tbl_load_valid_o && tbl_load_index_o == 4'h0 ##14 tbl_load_busy_o
    ##1 !tbl_load_busy_o && tbl_load_valid_o && tbl_load_index_o == 4'hF)
    else $error("load sequence wrong");
  cover property (wr_ctl && wr_data_i[16]);
  cover property (rd_c && addr_i == 12'h158 ##1 rd_data_o[17]);
  cover property (tbl_load_valid_o && tbl_load_index_o == 4'hF);
endmodule // vcr_monitor

bind vcr_resource_regs vcr_monitor mon_u (.*);

//--- testbench/vcr_resource_regs_tb.sv
/* self-checking bench for the vc0 resource registers.
   assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/1ps
module vcr_resource_regs_tb;
  logic        core_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
  logic        wr_en_i = 1'b0, rd_en_i = 1'b0, eeprom_load_i = 1'b0, neg_pending_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wr_data_i = 32'h00000000;
  logic [7:0]  eeprom_tc_map_i = 8'h00;
  logic [6:0]  eeprom_max_ts_i = 7'h00;
  logic [31:0] rd_data_o, tbl_load_data_o;
  logic [7:0]  tc_map_o;
  logic [2:0]  arb_select_o;
  logic [3:0]  tbl_load_index_o;
  logic        vc_enable_o, tbl_load_busy_o, tbl_load_valid_o;
  int          n_mismatch = 0;
  int          comparisons = 0;

  vcr_resource_regs dut_u (.*);

  initial forever #50 core_clk_i = ~core_clk_i;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    rd_en_i <= 1'b0;
    @(negedge core_clk_i);
    chk("rd_data_o", e, rd_data_o);
  endtask

  task automatic t_reset;
    rd(12'h150, 32'h047F0019);
    rd(12'h154, 32'h800000FF);
    rd(12'h158, 32'h00000000);
  endtask

  // every scheme code, reserved and read-only bits written as ones
  task automatic t_scheme;
    for (int s = 0; s < 8; s++) begin
      wr(12'h154, 32'h7FF0FF5A | (32'(s) << 17));
      rd(12'h154, 32'h0000005A | (32'(s == 3 ? 3 : 0) << 17));
      chk("vc_enable_o", 32'h00000000, {31'h0, vc_enable_o});
    end
    wr(12'h154, 32'h800000FF);
  endtask

  task automatic t_table;
    int n;
    n = 0;
    wr(12'h15C, 32'hFFFFFFFF);
    rd(12'h15C, 32'h00000000);
    wr(12'h180, 32'h12345678);
    rd(12'h158, 32'h00010000);
    wr(12'h154, 32'h800100FF);
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk_i);
      if (i == 0)
        chk("tbl_load_busy_o", 32'h00000001, {31'h0, tbl_load_busy_o});
      if (tbl_load_valid_o === 1'b1 && tbl_load_index_o === 4'h0)
        chk("tbl_load_data_o", 32'h12345678, tbl_load_data_o);
      if (tbl_load_valid_o === 1'b1)
        chk("tbl_load_index_o", 32'(n), {28'h0, tbl_load_index_o});
      if (tbl_load_valid_o === 1'b1) n++;
    end
    chk("load words", 32'h00000010, n);
    chk("tbl_load_busy_o", 32'h00000000, {31'h0, tbl_load_busy_o});
    rd(12'h158, 32'h00000000);
    rd(12'h154, 32'h800000FF);
  endtask

  task automatic t_neg;
    @(posedge core_clk_i);
    neg_pending_i <= 1'b1;
    rd(12'h158, 32'h00020000);
    @(posedge core_clk_i);
    neg_pending_i <= 1'b0;
    rd(12'h158, 32'h00000000);
  endtask

  task automatic t_eeprom;
    @(posedge core_clk_i);
    eeprom_load_i <= 1'b1;
    eeprom_tc_map_i <= 8'h3C;
    eeprom_max_ts_i <= 7'h15;
    @(posedge core_clk_i);
    eeprom_load_i <= 1'b0;
    rd(12'h150, 32'h04150019);
    rd(12'h154, 32'h8000003C);
  endtask

  // a write while the clock enable is low must leave the control register alone
  task automatic t_freeze;
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    addr_i <= 12'h154;
    wr_data_i <= 32'h00000000;
    wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
    ce_i <= 1'b1;
    rd(12'h154, 32'h8000003C);
  endtask

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_scheme;
    t_table;
    t_neg;
    t_eeprom;
    t_freeze;
    conclude;
  end
endmodule // vcr_resource_regs_tb
